// ### bench/sera_link_sva.sv
`include "sera_defs.svh"
`default_nettype none
module sera_link_sva #(
  parameter int QUARTER = 2
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic masterSdaOe,
  input wire logic devSdaOe
);
  localparam int STOP_MAX = 12 * QUARTER;
  logic sclLast;
  logic sdaLast;
  logic [3:0] bitCnt;
  logic [1:0] byteIdx;
  logic [7:0] addrByte;
  logic acked;
  logic ended;
  logic [3:0] next_bitCnt;
  logic [1:0] next_byteIdx;
  logic [7:0] next_addrByte;
  logic next_acked;
  logic next_ended;
  logic riseEv;
  logic startEv;
  logic stopEv;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Wire events seen from ref_clk; a START or STOP is an SDA edge while high
  assign riseEv = scl && !sclLast;
  assign startEv = scl && sclLast && sdaLast && !sda;
  assign stopEv = scl && sclLast && !sdaLast && sda;

  // Bit and byte position since START, direction bit, ack and NoACK seen
  always_comb begin
    next_bitCnt = bitCnt;
    next_byteIdx = byteIdx;
    next_addrByte = addrByte;
    next_acked = acked;
    next_ended = ended;
    if (startEv) begin
      next_bitCnt = 4'h0;
      next_byteIdx = 2'h0;
      next_ended = 1'b0;
    end else if (riseEv) begin
      next_bitCnt = (bitCnt == 4'h9) ? 4'h1 : bitCnt + 4'h1;
      if (bitCnt == 4'h9 && byteIdx != 2'h3) begin
        next_byteIdx = byteIdx + 2'h1;
      end
      if (byteIdx == 2'h0 && bitCnt < 4'h8) begin
        next_addrByte = {addrByte[6:0], sda};
      end
      if (bitCnt == 4'h8 && byteIdx == 2'h0) begin
        next_acked = !sda;
      end
      if (bitCnt == 4'h8 && byteIdx != 2'h0 && addrByte[0]) begin
        next_ended = sda;
      end
    end
  end

  // Registers only; saturating byte index keeps the width small
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
      bitCnt <= 4'h0;
      byteIdx <= 2'h0;
      addrByte <= 8'h00;
      acked <= 1'b0;
      ended <= 1'b0;
    end else begin
      sclLast <= scl;
      sdaLast <= sda;
      bitCnt <= next_bitCnt;
      byteIdx <= next_byteIdx;
      addrByte <= next_addrByte;
      acked <= next_acked;
      ended <= next_ended;
    end
  end

  oe_on_fall_a: assert property ($changed(devSdaOe) |-> $fell(scl))
    else $error("device data changed away from a falling clock");
  ninth_release_a: assert property (addrByte[0] && byteIdx != 2'h0
      && bitCnt == 4'h9 && scl && sclLast |-> !devSdaOe)
    else $error("device held data in the ninth clock");
  master_quiet_a: assert property (addrByte[0] && acked && !ended
      && byteIdx != 2'h0 && bitCnt inside {[4'h1:4'h8]} && scl && sclLast
      |-> !masterSdaOe)
    else $error("master drove data during a read byte");
  nack_stop_a: assert property ($rose(ended) |-> ##[1:STOP_MAX] stopEv)
    else $error("no STOP after NoACK");
  stop_release_a: assert property (stopEv |-> !devSdaOe [*8])
    else $error("device drives after STOP");
  addr_prefix_a: assert property (byteIdx == 2'h0 && bitCnt == 4'h9
      && scl && devSdaOe |-> addrByte[7:4] == `SERA_SLAVE_PREFIX)
    else $error("device acked a foreign prefix");
  baddr_ack_a: assert property (!addrByte[0] && acked && byteIdx == 2'h1
      && bitCnt == 4'h9 && scl && sclLast |-> devSdaOe)
    else $error("byte address not acked");
  start_stop_only_a: assert property (scl && sclLast
      && $changed(masterSdaOe) |-> startEv || stopEv)
    else $error("data moved while clock high");
endmodule : sera_link_sva
`default_nettype wire

// ### bench/sera_tb.sv
`default_nettype none
module sera_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QUARTER = 2;
  localparam int LIMIT = 40000;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdReady;
  logic cmdSelective = 1'b0;
  logic [2:0] cmdSelect = 3'h0;
  logic [7:0] cmdAddr = 8'h00;
  logic [7:0] cmdCount = 8'h00;
  logic rdValid;
  logic rdReady = 1'b0;
  logic [7:0] rdData;
  logic doneValid;
  logic doneNack;
  logic [2:0] strap = 3'h5;
  logic loadWe = 1'b0;
  logic [6:0] loadAddr = 7'h00;
  logic [7:0] loadData = 8'h00;
  logic busy;
  logic [7:0] addrPtr;
  logic [15:0] lfsrLoad = 16'h2FFD;
  logic [15:0] lfsrReady = 16'h2FFD;
  logic hold = 1'b0;
  logic quiet = 1'b0;
  logic [7:0] ptr = 8'h00;
  sera_pkg::sera_byte_t expMem [128];
  sera_pkg::sera_byte_t expQ [$];
  logic nackQ [$];
  logic [7:0] ptrQ [$];
  int skipN = 0;
  int errors = 0;
  int checked = 0;

  sera_link_if sera_link_if_i ();
  sera_master #(.QUARTER(QUARTER)) sera_master_i (.ref_clk(ref_clk),
    .nrst(nrst), .link(sera_link_if_i.master), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdSelective(cmdSelective),
    .cmdSelect(cmdSelect), .cmdAddr(cmdAddr), .cmdCount(cmdCount),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
    .doneValid(doneValid), .doneNack(doneNack));
  sera_device sera_device_i (.link(sera_link_if_i.device), .nrst(nrst),
    .deviceSelectBit0(strap[0]), .deviceSelectBit1(strap[1]),
    .deviceSelectBit2(strap[2]), .loadWe(loadWe), .loadAddr(loadAddr),
    .loadData(loadData), .busy(busy), .addrPtr(addrPtr));
  sera_link_sva #(.QUARTER(QUARTER)) sera_link_sva_i (.ref_clk(ref_clk),
    .nrst(nrst), .scl(sera_link_if_i.scl), .sda(sera_link_if_i.sda),
    .masterSdaOe(sera_link_if_i.masterSdaOe),
    .devSdaOe(sera_link_if_i.devSdaOe));

  // 250 MHz system clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("errors %0d, checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Note the bytes and final pointer, issue one read, wait for its end
  task automatic run(input logic sel, input logic [2:0] blk,
      input logic [7:0] addr, input logic [7:0] cnt, input logic nack);
    int n;
    if (!nack) begin
      if (sel) begin
        ptr = addr;
      end
      for (int i = 0; i <= cnt; i++) begin
        if (!quiet) begin
          expQ.push_back(expMem[ptr[6:0]]);
        end
        ptr = ptr + 8'h01;
      end
    end
    nackQ.push_back(nack);
    ptrQ.push_back(ptr);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < LIMIT);
    cmdSelective = sel;
    cmdSelect = blk;
    cmdAddr = addr;
    cmdCount = cnt;
    cmdValid = 1'b1;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    while (nackQ.size() != 0 && n < LIMIT) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= LIMIT) begin
      errors++;
      summarize();
    end
  endtask : run

  // Random back-pressure; held low to force the buffer full
  always @(negedge ref_clk) begin
    lfsrReady <= lfsr_step(lfsrReady);
    rdReady <= !hold && lfsrReady[0];
  end

  // Wait for an scl level at falling ref_clk; a stuck link ends the run
  task automatic wait_scl(input logic level);
    int n;
    n = 0;
    while (sera_link_if_i.scl !== level && n < LIMIT) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= LIMIT) begin
      errors++;
      summarize();
    end
  endtask : wait_scl

  // Load the array during the first read; the load port only sees scl
  initial begin
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < LIMIT) begin
      @(negedge ref_clk);
      n++;
    end
    for (int i = 0; i < 128; i++) begin
      wait_scl(1'b0);
      wait_scl(1'b1);
      lfsrLoad = lfsr_step(lfsrLoad);
      loadWe = 1'b1;
      loadAddr = i[6:0];
      loadData = lfsrLoad[7:0];
      expMem[i] = lfsrLoad[7:0];
    end
    wait_scl(1'b0);
    wait_scl(1'b1);
    loadWe = 1'b0;
  end

  // Compare each popped byte and each end of transfer with the notes
  always @(posedge ref_clk) begin
    if (rdValid === 1'b1 && rdReady === 1'b1) begin
      if (skipN != 0) begin
        skipN--;
      end else begin
        check(rdData, (expQ.size() != 0) ? expQ.pop_front() : 8'hXX);
      end
    end
    if (doneValid === 1'b1 && nackQ.size() != 0) begin
      check({7'h00, doneNack}, {7'h00, nackQ.pop_front()});
      check(addrPtr, ptrQ.pop_front());
      check({7'h00, busy}, 8'h00);
    end
  end

  // Data of the fill pass is unknown while loads race it, so skipped
  initial begin
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    quiet = 1'b1;
    skipN = 256;
    run(1'b0, 3'h5, 8'h00, 8'hFF, 1'b0);
    quiet = 1'b0;
    run(1'b1, 3'h5, 8'h0E, 8'h03, 1'b0);
    run(1'b0, 3'h5, 8'h00, 8'h00, 1'b0);
    run(1'b1, 3'h5, 8'h7E, 8'h03, 1'b0);
    run(1'b1, 3'h5, 8'hFF, 8'h01, 1'b0);
    run(1'b1, 3'h3, 8'h20, 8'h00, 1'b1);
    run(1'b0, 3'h5, 8'h00, 8'h00, 1'b0);
    hold = 1'b1;
    fork
      begin
        repeat (1500) @(negedge ref_clk);
        check({7'h00, busy}, 8'h01);
        check({7'h00, rdValid}, 8'h01);
        hold = 1'b0;
      end
    join_none
    run(1'b0, 3'h5, 8'h00, 8'h0B, 1'b0);
    summarize();
  end
endmodule : sera_tb
`default_nettype wire

// ### rtl/sera_defs.svh
`ifndef SERA_DEFS_SVH
`define SERA_DEFS_SVH
// Behaviour
// - Read-direction address reads current byte address
// - Ack address, shift byte, await master answer
// - NoACK then STOP returns device to standby
// - Master dummy-writes byte address before selective read
// - Master repeats START, then read-direction address
// - Selective read sends byte at loaded address
// - Master ends single read with NoACK, STOP
// - Master ACK keeps bytes flowing from successive locations
// - Counter crosses pages, wraps at memory end
// - 1-Kb counter does not wrap at 128
// - Match prefix 1010; last bit selects read
// - Release data line during ninth clock
// - Select bits match pins or carry address
// - Sample on rising clock, change on falling
`define SERA_CLK_NS 4
`define SERA_SCL_PERIOD_NS 2500
`define SERA_QUARTER ((`SERA_SCL_PERIOD_NS + 4 * `SERA_CLK_NS - 1) / (4 * `SERA_CLK_NS))
`define SERA_SLAVE_PREFIX 4'hA
`define SERA_MEM_BITS 7
`define SERA_MEM_RESET 8'hFF
`define SERA_ADDR_RESET 11'h000
`define SERA_WAKE_SLOTS 4'h8
`define SERA_WAKE_RELEASE 4'h4
`define SERA_FIFO_DEPTH 8
`endif

// ### rtl/sera_device.sv
`include "sera_defs.svh"
`default_nettype none
module sera_device #(
  parameter int MEM_BITS = `SERA_MEM_BITS
) (
  sera_link_if.device link,
  input wire logic nrst,
  input wire logic deviceSelectBit0,
  input wire logic deviceSelectBit1,
  input wire logic deviceSelectBit2,
  input wire logic loadWe,
  input wire logic [MEM_BITS-1:0] loadAddr,
  input wire logic [7:0] loadData,
  output logic busy,
  output logic [((MEM_BITS < 8) ? 8 : MEM_BITS)-1:0] addrPtr
);
  // A 1-Kb part still counts over a full byte, so it aliases, not wraps
  localparam int CNT_BITS = (MEM_BITS < 8) ? 8 : MEM_BITS;
  localparam int NBLK = (MEM_BITS > 8) ? MEM_BITS - 8 : 0;
  localparam int DEPTH = 1 << MEM_BITS;

  sera_pkg::sera_dev_state_t state, next_state;
  sera_pkg::sera_byte_t mem [DEPTH];
  sera_pkg::sera_byte_t next_mem [DEPTH];
  sera_pkg::sera_byte_t shift, next_shift, rxByte, txByte;
  logic [2:0] cnt, next_cnt;
  logic [2:0] blk, next_blk;
  logic [CNT_BITS-1:0] addr, next_addr;
  logic [10:0] fullAddr;
  logic oe, next_oe;
  logic sdaRise;
  logic rstMeta, rstSync;
  logic [2:0] selMeta, selSync, selOk;
  logic startEv, stopEv, hit;

  // Only the rising edge samples data bits; START/STOP look at SDA at the falling edge
  always_ff @(posedge link.scl) begin
    sdaRise <= link.sda;
  end

  // Reset and straps come from outside; two falling-edge flops each
  always_ff @(negedge link.scl) begin
    rstMeta <= nrst && link.linkNrst;
    rstSync <= rstMeta;
    selMeta <= {deviceSelectBit2, deviceSelectBit1, deviceSelectBit0};
    selSync <= selMeta;
  end

  // A change of SDA between rising and falling edge is START or STOP.
  // Trade-off: with SCL as the only clock, the condition is seen at the
  // falling edge that follows it rather than at the SDA edge itself.
  assign startEv = sdaRise && !link.sda;
  assign stopEv = !sdaRise && link.sda;
  assign rxByte = {shift[6:0], sdaRise};
  assign txByte = mem[addr[MEM_BITS-1:0]];
  assign fullAddr = {blk, rxByte};

  // Select bits either match the straps or are memory address bits
  for (genvar i = 0; i < 3; i++) begin : g_sel
    assign selOk[i] = (i < NBLK) || (rxByte[i+1] == selSync[i]);
  end
  assign hit = rxByte[7:4] == `SERA_SLAVE_PREFIX && &selOk;

  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe = oe;
  assign busy = state != sera_pkg::DEV_IDLE;
  assign addrPtr = addr;

  // Whole protocol runs at the falling edge, where SDA may change
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_cnt = cnt;
    next_blk = blk;
    next_addr = addr;
    next_oe = oe;
    next_mem = mem;
    if (loadWe) begin
      next_mem[loadAddr] = loadData;
    end
    if (startEv) begin
      next_state = sera_pkg::DEV_ADDR;
      next_cnt = 3'h0;
      next_oe = 1'b0;
    end else if (stopEv) begin
      next_state = sera_pkg::DEV_IDLE;
      next_oe = 1'b0;
    end else begin
      case (state)
        sera_pkg::DEV_ADDR: begin
          next_shift = rxByte;
          next_cnt = cnt + 3'h1;
          if (cnt == 3'h7) begin
            if (hit) begin
              next_state = sera_pkg::DEV_ACKA;
              next_oe = 1'b1;
            end else begin
              next_state = sera_pkg::DEV_IDLE;
            end
          end
        end
        sera_pkg::DEV_ACKA: begin
          next_cnt = 3'h0;
          next_blk = shift[3:1];
          if (shift[0]) begin
            // Byte goes out at once from the current address
            next_shift = txByte;
            next_oe = !txByte[7];
            next_state = sera_pkg::DEV_TX;
          end else begin
            next_oe = 1'b0;
            next_state = sera_pkg::DEV_WADDR;
          end
        end
        sera_pkg::DEV_WADDR: begin
          next_shift = rxByte;
          next_cnt = cnt + 3'h1;
          if (cnt == 3'h7) begin
            next_addr = fullAddr[CNT_BITS-1:0];
            next_oe = 1'b1;
            next_state = sera_pkg::DEV_ACKW;
          end
        end
        sera_pkg::DEV_ACKW: begin
          // Data bytes of a write are outside this engine: not acked
          next_oe = 1'b0;
          next_state = sera_pkg::DEV_IDLE;
        end
        sera_pkg::DEV_TX: begin
          next_cnt = cnt + 3'h1;
          if (cnt == 3'h7) begin
            next_oe = 1'b0;
            next_addr = addr + 1'b1;
            next_state = sera_pkg::DEV_RACK;
          end else begin
            next_shift = {shift[6:0], 1'b0};
            next_oe = !shift[6];
          end
        end
        sera_pkg::DEV_RACK: begin
          next_cnt = 3'h0;
          if (!sdaRise) begin
            next_shift = txByte;
            next_oe = !txByte[7];
            next_state = sera_pkg::DEV_TX;
          end else begin
            next_oe = 1'b0;
            next_state = sera_pkg::DEV_IDLE;
          end
        end
        default: begin
          next_oe = 1'b0;
          next_state = sera_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // Power-up content is the erased state, all bytes 8'hFF
  always_ff @(negedge link.scl) begin
    if (!rstSync) begin
      state <= sera_pkg::DEV_IDLE;
      shift <= 8'h00;
      cnt <= 3'h0;
      blk <= 3'h0;
      addr <= CNT_BITS'(`SERA_ADDR_RESET);
      oe <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= `SERA_MEM_RESET;
      end
    end else begin
      state <= next_state;
      shift <= next_shift;
      cnt <= next_cnt;
      blk <= next_blk;
      addr <= next_addr;
      oe <= next_oe;
      mem <= next_mem;
    end
  end
endmodule : sera_device
`default_nettype wire

// ### rtl/sera_fifo.sv
`include "sera_defs.svh"
`default_nettype none
module sera_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SERA_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // Flags come straight from the occupancy count
  assign inReady = count != (AW + 1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Pointers wrap at DEPTH so non power-of-two depths work too
  always_comb begin
    next_mem = mem;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (push) begin
      next_mem[wrPtr] = inData;
      next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
    end
    if (pop) begin
      next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Storage needs no reset; only the pointers and the count do
  always_ff @(posedge ref_clk) begin
    mem <= next_mem;
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end
endmodule : sera_fifo
`default_nettype wire

// ### rtl/sera_link_if.sv
`default_nettype none
interface sera_link_if;
  logic scl;
  logic masterSdaOut;
  logic masterSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic linkNrst;
  logic sda;
  // Open-drain wire with pull-up: low when any enabled driver pulls low
  assign sda = !((masterSdaOe && !masterSdaOut) || (devSdaOe && !devSdaOut));
  modport master (
    output scl, masterSdaOut, masterSdaOe, linkNrst,
    input sda
  );
  modport device (
    input scl, sda, linkNrst,
    output devSdaOut, devSdaOe
  );
endinterface : sera_link_if
`default_nettype wire

// ### rtl/sera_master.sv
`include "sera_defs.svh"
`default_nettype none
module sera_master #(
  parameter int QUARTER = `SERA_QUARTER,
  parameter int FIFO_DEPTH = `SERA_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic nrst,
  sera_link_if.master link,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdSelective,
  input wire logic [2:0] cmdSelect,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdCount,
  output logic rdValid,
  input wire logic rdReady,
  output logic [7:0] rdData,
  output logic doneValid,
  output logic doneNack
);
  sera_pkg::sera_mst_state_t state, next_state;
  logic [15:0] div, next_div;
  logic [1:0] q, next_q;
  logic [2:0] bitCnt, next_bitCnt, sel, next_sel;
  logic [3:0] wake, next_wake;
  sera_pkg::sera_byte_t shift, next_shift, addrReg, next_addrReg;
  logic [7:0] remain, next_remain;
  logic slotA, next_slotA, slotB, next_slotB, selective, next_selective;
  logic sampled, next_sampled, nack, next_nack, done, next_done;
  logic linkNrst, next_linkNrst, sclReg, next_scl, sdaOe, next_sdaOe;
  logic sdaMeta, sdaSync, running, tick, slotEnd, fifoReady, pushNow;

  // Read bytes wait here; a full buffer stalls the bus with SCL low
  sera_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) sera_fifo_i (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .inValid(pushNow),
    .inReady(fifoReady),
    .inData(shift),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData)
  );

  assign running = state != sera_pkg::M_IDLE && state != sera_pkg::M_PUSH;
  assign tick = running && div == 16'(QUARTER - 1);
  assign slotEnd = tick && q == 2'h3;
  assign pushNow = state == sera_pkg::M_PUSH;
  assign cmdReady = state == sera_pkg::M_IDLE;
  assign link.scl = sclReg;
  assign link.masterSdaOut = 1'b0;
  assign link.masterSdaOe = sdaOe;
  assign link.linkNrst = linkNrst;
  assign doneValid = done;
  assign doneNack = nack;

  // Every slot is four quarters: SCL 0,1,1,0 with SDA a,a,b,b
  always_comb begin
    next_state = state;
    next_div = running ? (tick ? 16'h0000 : div + 16'h0001) : 16'h0000;
    next_q = tick ? q + 2'h1 : q;
    next_bitCnt = bitCnt;
    next_sel = sel;
    next_wake = wake;
    next_shift = shift;
    next_addrReg = addrReg;
    next_remain = remain;
    next_slotA = slotA;
    next_slotB = slotB;
    next_selective = selective;
    next_sampled = (tick && q == 2'h2) ? sdaSync : sampled;
    next_nack = nack;
    next_done = 1'b0;
    next_linkNrst = wake >= `SERA_WAKE_RELEASE;
    case (state)
      sera_pkg::M_WAKE: if (slotEnd) begin
        next_wake = wake + 4'h1;
        if (wake == `SERA_WAKE_SLOTS - 4'h1) next_state = sera_pkg::M_IDLE;
      end
      sera_pkg::M_IDLE: if (cmdValid) begin
        next_state = sera_pkg::M_START;
        next_q = 2'h0;
        next_sel = cmdSelect;
        next_addrReg = cmdAddr;
        next_remain = cmdCount;
        next_selective = cmdSelective;
        next_nack = 1'b0;
        next_slotA = 1'b1;
        next_slotB = 1'b0;
      end
      sera_pkg::M_START: if (slotEnd) begin
        next_shift = {`SERA_SLAVE_PREFIX, sel, !selective};
        next_slotA = 1'(`SERA_SLAVE_PREFIX >> 3);
        next_slotB = 1'(`SERA_SLAVE_PREFIX >> 3);
        next_bitCnt = 3'h0;
        next_state = selective ? sera_pkg::M_SADDR : sera_pkg::M_RADDR;
      end
      sera_pkg::M_SADDR, sera_pkg::M_BADDR, sera_pkg::M_RADDR:
        if (slotEnd) begin
          next_bitCnt = bitCnt + 3'h1;
          next_shift = {shift[6:0], 1'b0};
          next_slotA = shift[6];
          next_slotB = shift[6];
          if (bitCnt == 3'h7) begin
            next_slotA = 1'b1;
            next_slotB = 1'b1;
            next_state = state == sera_pkg::M_SADDR ? sera_pkg::M_SACK :
                         state == sera_pkg::M_BADDR ? sera_pkg::M_BACK :
                         sera_pkg::M_RACK;
          end
        end
      sera_pkg::M_SACK, sera_pkg::M_BACK, sera_pkg::M_RACK:
        if (slotEnd) begin
          next_bitCnt = 3'h0;
          if (sampled) begin
            next_nack = 1'b1;
            next_slotA = 1'b0;
            next_slotB = 1'b1;
            next_state = sera_pkg::M_STOP;
          end else if (state == sera_pkg::M_SACK) begin
            next_shift = addrReg;
            next_slotA = addrReg[7];
            next_slotB = addrReg[7];
            next_state = sera_pkg::M_BADDR;
          end else if (state == sera_pkg::M_BACK) begin
            next_selective = 1'b0;
            next_slotA = 1'b1;
            next_slotB = 1'b0;
            next_state = sera_pkg::M_START;
          end else begin
            next_state = sera_pkg::M_RDATA;
          end
        end
      sera_pkg::M_RDATA: if (slotEnd) begin
        next_shift = {shift[6:0], sampled};
        next_bitCnt = bitCnt + 3'h1;
        if (bitCnt == 3'h7) next_state = sera_pkg::M_PUSH;
      end
      sera_pkg::M_PUSH: if (fifoReady) begin
        next_q = 2'h0;
        next_slotA = remain == 8'h00;
        next_slotB = remain == 8'h00;
        next_state = sera_pkg::M_MACK;
      end
      sera_pkg::M_MACK: if (slotEnd) begin
        next_bitCnt = 3'h0;
        // Next data byte needs SDA released; STOP needs it low first
        next_slotA = remain != 8'h00;
        next_slotB = 1'b1;
        next_remain = remain - 8'h01;
        next_state = remain == 8'h00 ? sera_pkg::M_STOP : sera_pkg::M_RDATA;
      end
      sera_pkg::M_STOP: if (slotEnd) begin
        next_done = 1'b1;
        next_state = sera_pkg::M_IDLE;
      end
      default: next_state = sera_pkg::M_IDLE;
    endcase
    // Pins are registered from the next values, so they never glitch
    if (next_state == sera_pkg::M_IDLE) begin
      next_scl = 1'b1;
      next_sdaOe = 1'b0;
    end else if (next_state == sera_pkg::M_PUSH) begin
      next_scl = 1'b0;
      next_sdaOe = 1'b0;
    end else begin
      next_scl = next_q == 2'h1 || next_q == 2'h2;
      next_sdaOe = !(next_q[1] ? next_slotB : next_slotA);
    end
  end

  // SDA comes from the pin, so two flops before use
  always_ff @(posedge ref_clk) begin
    sdaMeta <= link.sda;
    sdaSync <= sdaMeta;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= sera_pkg::M_WAKE;
      div <= 16'h0000;
      q <= 2'h0;
      bitCnt <= 3'h0;
      sel <= 3'h0;
      wake <= 4'h0;
      shift <= 8'h00;
      addrReg <= 8'h00;
      remain <= 8'h00;
      slotA <= 1'b1;
      slotB <= 1'b1;
      selective <= 1'b0;
      sampled <= 1'b1;
      nack <= 1'b0;
      done <= 1'b0;
      linkNrst <= 1'b0;
      sclReg <= 1'b1;
      sdaOe <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      q <= next_q;
      bitCnt <= next_bitCnt;
      sel <= next_sel;
      wake <= next_wake;
      shift <= next_shift;
      addrReg <= next_addrReg;
      remain <= next_remain;
      slotA <= next_slotA;
      slotB <= next_slotB;
      selective <= next_selective;
      sampled <= next_sampled;
      nack <= next_nack;
      done <= next_done;
      linkNrst <= next_linkNrst;
      sclReg <= next_scl;
      sdaOe <= next_sdaOe;
    end
  end
endmodule : sera_master
`default_nettype wire

// ### rtl/sera_pkg.sv
`default_nettype none
package sera_pkg;
  typedef logic [7:0] sera_byte_t;
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_ADDR, DEV_ACKA, DEV_WADDR, DEV_ACKW, DEV_TX, DEV_RACK
  } sera_dev_state_t;
  typedef enum logic [3:0] {
    M_WAKE, M_IDLE, M_START, M_SADDR, M_SACK, M_BADDR, M_BACK,
    M_RADDR, M_RACK, M_RDATA, M_PUSH, M_MACK, M_STOP
  } sera_mst_state_t;
endpackage : sera_pkg
`default_nettype wire
